//--- rmwt_host.sv
`default_nettype none
module rmwt_host
	import rmwt_pkg::*;
(
	// Bus side
	input  wire logic      clk,
	output var  rmwt_req_t req,
	// Goal strobes
	output var  logic      first_goal_wr,
	output var  logic      second_goal_wr
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		req = '0;
		first_goal_wr = 1'b0;
		second_goal_wr = 1'b0;
	end
	// Released address and data inverted, wr and rd cleared, so stale values never match
	task automatic xfer(input logic [6:0] a, input logic w, input logic [31:0] d);
		@(negedge clk);
		req <= '{addr: a, wr: w, rd: !w, wdata: d};
		@(negedge clk);
		req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
	endtask
	// Synced mode: caller writes second axis goal last
	task automatic goal(input logic f, input logic s);
		@(negedge clk);
		first_goal_wr <= f;
		second_goal_wr <= s;
		@(negedge clk);
		first_goal_wr <= 1'b0;
		second_goal_wr <= 1'b0;
	endtask
endmodule // rmwt_host
`default_nettype wire

//--- rmwt_pkg.sv
`default_nettype none
package rmwt_pkg;
	// Register addresses
	localparam logic [6:0]  ADDR_PROFILE      = 7'h07;
	localparam logic [6:0]  ADDR_TABLE_INDEX  = 7'h08;
	localparam logic [6:0]  ADDR_TABLE_WORD   = 7'h09;
	// Profile select fields
	localparam int          SECOND_CODE_LSB   = 2;
	localparam int          FIRST_CODE_LSB    = 0;
	localparam int          CODE_W            = 2;
	localparam int          SYNC_UPDATE_BIT   = 8;
	localparam int          INTERP_BIT        = 9;
	localparam int          INDEX_W           = 5;
	// Table layout: ten words per axis, bit 4 of the index picks the axis
	localparam int          AXIS_WORDS        = 10;
	localparam int          TABLE_WORDS       = 20;
	localparam logic [3:0]  LAST_WORD_IN_AXIS = 4'h9;
	localparam int          AXIS_SEL_BIT      = 4;
	// Reset values
	localparam logic [1:0]  CODE_RST          = 2'h0;
	localparam logic [4:0]  INDEX_RST         = 5'h00;
	localparam logic [31:0] TABLE_WORD_RST    = 32'haaaa_b554;
	localparam logic [31:0] ZERO_WORD         = 32'h0000_0000;

	typedef enum logic [1:0] {
		RMWT_POSITIONING = 2'b00,
		RMWT_VEL_POS     = 2'b01,
		RMWT_VEL_NEG     = 2'b10,
		RMWT_HOLD        = 2'b11
	} rmwt_code_t;

	// Per-axis decoded behaviour for the ramp generator
	typedef struct packed {
		logic positioning;
		logic to_pos_peak;
		logic to_neg_peak;
		logic hold_velocity;
	} rmwt_behave_t;

	typedef struct packed {
		logic       interp_en;
		logic       sync_update;
		rmwt_code_t second_code;
		rmwt_code_t first_code;
	} rmwt_profile_t;

	typedef struct packed {
		logic [6:0]  addr;
		logic        wr;
		logic        rd;
		logic [31:0] wdata;
	} rmwt_req_t;
endpackage
`default_nettype wire

//--- rmwt_regs.sv
`default_nettype none
module rmwt_regs
	import rmwt_pkg::*;
(
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          reset_n,
	input  wire logic          ce,
	// Register access from the serial front end
	input  wire rmwt_req_t     req,
	output var  logic [31:0]   rdata_q,
	// Goal position write strobes from the target registers
	input  wire logic          first_goal_wr,
	input  wire logic          second_goal_wr,
	// To the ramp generators
	output var  rmwt_profile_t profile_q,
	output var  rmwt_behave_t  first_behave_q,
	output var  rmwt_behave_t  second_behave_q,
	output var  logic          first_goal_load_q,
	output var  logic          second_goal_load_q,
	// To the microstep indexers
	output var  logic [31:0]   table_q [TABLE_WORDS],
	output var  logic [4:0]    index_q
);

	function automatic rmwt_behave_t decode_code(input rmwt_code_t c);
		rmwt_behave_t b;
		b = '0;
		unique case (c)
			RMWT_POSITIONING: b.positioning   = 1'b1;
			RMWT_VEL_POS:     b.to_pos_peak   = 1'b1;
			RMWT_VEL_NEG:     b.to_neg_peak   = 1'b1;
			RMWT_HOLD:        b.hold_velocity = 1'b1;
		endcase
		return b;
	endfunction

	// Flat table slot for an index, valid only for mapped codes
	function automatic logic index_mapped(input logic [4:0] i);
		return (i[3:0] <= LAST_WORD_IN_AXIS);
	endfunction

	function automatic logic [4:0] index_slot(input logic [4:0] i);
		logic [4:0] base;
		base = i[AXIS_SEL_BIT] ? 5'(AXIS_WORDS) : 5'h00;
		return base + {1'b0, i[3:0]};
	endfunction

	logic          wr_profile;
	logic          wr_index;
	logic          wr_word;
	logic          rd_any;
	rmwt_profile_t profile_d;
	logic [31:0]   word_view;

	assign wr_profile = ce && req.wr && (req.addr == ADDR_PROFILE);
	assign wr_index   = ce && req.wr && (req.addr == ADDR_TABLE_INDEX);
	assign wr_word    = ce && req.wr && (req.addr == ADDR_TABLE_WORD);
	assign rd_any     = ce && req.rd;

	// Selected word; unmapped codes read as zero
	assign word_view  = index_mapped(index_q) ? table_q[index_slot(index_q)]
		: ZERO_WORD;

	always_comb begin
		profile_d             = profile_q;
		profile_d.first_code  = rmwt_code_t'(req.wdata[FIRST_CODE_LSB +: CODE_W]);
		profile_d.second_code = rmwt_code_t'(req.wdata[SECOND_CODE_LSB +: CODE_W]);
		profile_d.sync_update = req.wdata[SYNC_UPDATE_BIT];
		profile_d.interp_en   = req.wdata[INTERP_BIT];
	end

	// Profile register and its decoded copies, kept in step
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			profile_q       <= '{1'b0, 1'b0, RMWT_POSITIONING, RMWT_POSITIONING};
			first_behave_q  <= '{positioning: 1'b1, default: 1'b0};
			second_behave_q <= '{positioning: 1'b1, default: 1'b0};
		end else if (wr_profile) begin
			profile_q       <= profile_d;
			first_behave_q  <= decode_code(profile_d.first_code);
			second_behave_q <= decode_code(profile_d.second_code);
		end
	end

	// Goal commits; synced mode waits for the second axis write, so the host
	// must write the second axis goal last
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			first_goal_load_q  <= 1'b0;
			second_goal_load_q <= 1'b0;
		end else if (ce) begin
			if (profile_q.sync_update) begin
				first_goal_load_q  <= second_goal_wr;
				second_goal_load_q <= second_goal_wr;
			end else begin
				first_goal_load_q  <= first_goal_wr;
				second_goal_load_q <= second_goal_wr;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			index_q <= INDEX_RST;
		end else if (wr_index) begin
			index_q <= req.wdata[INDEX_W-1:0];
		end
	end

	// Table storage; unmapped slots simply drop the write
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int k = 0; k < TABLE_WORDS; k++) begin
				table_q[k] <= TABLE_WORD_RST;
			end
		end else if (wr_word && index_mapped(index_q)) begin
			table_q[index_slot(index_q)] <= req.wdata;
		end
	end

	// Read data held until the next read
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_q <= ZERO_WORD;
		end else if (rd_any) begin
			unique case (req.addr)
				ADDR_PROFILE:     rdata_q <= {22'h0, profile_q.interp_en,
					profile_q.sync_update, 4'h0, profile_q.second_code,
					profile_q.first_code};
				ADDR_TABLE_INDEX: rdata_q <= {27'h0, index_q};
				ADDR_TABLE_WORD:  rdata_q <= word_view;
				default:          rdata_q <= ZERO_WORD;
			endcase
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence word_read_s;
		rd_any && req.addr == ADDR_TABLE_WORD && !req.wr;
	endsequence

	sequence profile_write_s;
		wr_profile;
	endsequence

	profile_fields_a: assert property (profile_write_s |=>
		profile_q.first_code == $past(req.wdata[1:0]) &&
		profile_q.second_code == $past(req.wdata[3:2]))
		else $error("profile codes did not take written value");

	interp_bit_a: assert property (profile_write_s |=>
		profile_q.interp_en == $past(req.wdata[9]))
		else $error("interpolation bit not stored");

	sync_bit_a: assert property (profile_write_s |=>
		profile_q.sync_update == $past(req.wdata[8]))
		else $error("sync update bit not stored");

	behave_match_a: assert property (
		$onehot(first_behave_q) && first_behave_q == decode_code(profile_q.first_code) &&
		second_behave_q == decode_code(profile_q.second_code))
		else $error("decoded behaviour disagrees with profile code");

	sync_hold_a: assert property (ce && profile_q.sync_update && first_goal_wr &&
		!second_goal_wr |=> !first_goal_load_q)
		else $error("first axis goal committed early in synced mode");

	sync_commit_a: assert property (ce && profile_q.sync_update && second_goal_wr
		|=> first_goal_load_q && second_goal_load_q)
		else $error("synced commit did not load both axes");

	index_store_a: assert property (wr_index |=>
		index_q == $past(req.wdata[4:0]))
		else $error("table index not stored");

	word_read_a: assert property (word_read_s ##0 index_mapped(index_q)
		|=> rdata_q == $past(table_q[index_slot(index_q)]))
		else $error("table word read mismatch");

	unmapped_read_a: assert property (word_read_s ##0 !index_mapped(index_q)
		|=> rdata_q == ZERO_WORD)
		else $error("unmapped index did not read zero");

	second_axis_a: assert property (wr_word && index_q == 5'h10
		|=> table_q[AXIS_WORDS] == $past(req.wdata))
		else $error("second axis first word not written");

	// Fold of the whole table; one stray or lost write flips it when it changes the stored word
	logic [31:0] table_fold;

	always_comb begin
		table_fold = ZERO_WORD;
		for (int k = 0; k < TABLE_WORDS; k++) begin
			table_fold = table_fold ^ table_q[k];
		end
	end

	sequence frozen_s;
		!ce;
	endsequence

	sequence synced_commit_s;
		ce && profile_q.sync_update && second_goal_wr;
	endsequence

	sequence both_loaded_s;
		first_goal_load_q && second_goal_load_q;
	endsequence

	sequence strobes_idle_s;
		ce && !first_goal_wr && !second_goal_wr;
	endsequence

	sequence unmapped_write_s;
		wr_word && !index_mapped(index_q);
	endsequence

	positioning_decode_a: assert property (
		(profile_q.first_code == RMWT_POSITIONING) == first_behave_q.positioning &&
		(profile_q.second_code == RMWT_POSITIONING) == second_behave_q.positioning)
		else $error("positioning decode wrong");

	pos_peak_a: assert property (
		(profile_q.first_code == RMWT_VEL_POS) == first_behave_q.to_pos_peak &&
		(profile_q.second_code == RMWT_VEL_POS) == second_behave_q.to_pos_peak)
		else $error("positive velocity decode wrong");

	neg_peak_a: assert property (
		(profile_q.first_code == RMWT_VEL_NEG) == first_behave_q.to_neg_peak &&
		(profile_q.second_code == RMWT_VEL_NEG) == second_behave_q.to_neg_peak)
		else $error("negative velocity decode wrong");

	hold_decode_a: assert property (
		(profile_q.first_code == RMWT_HOLD) == first_behave_q.hold_velocity &&
		(profile_q.second_code == RMWT_HOLD) == second_behave_q.hold_velocity)
		else $error("hold decode wrong");

	second_onehot_a: assert property ($onehot(second_behave_q))
		else $error("second axis decode not one-hot");

	profile_hold_a: assert property (!wr_profile |=> $stable(profile_q))
		else $error("profile changed without a write");

	frozen_state_a: assert property (frozen_s |=> $stable(profile_q) &&
		$stable(index_q) && $stable(rdata_q) && $stable(table_fold) &&
		$stable(first_goal_load_q) && $stable(second_goal_load_q))
		else $error("state moved while clock enable low");

	profile_read_a: assert property (rd_any && req.addr == ADDR_PROFILE |=>
		rdata_q[1:0] == $past(profile_q.first_code) &&
		rdata_q[3:2] == $past(profile_q.second_code) &&
		rdata_q[9:8] == {$past(profile_q.interp_en), $past(profile_q.sync_update)} &&
		rdata_q[31:10] == 22'h0 && rdata_q[7:4] == 4'h0)
		else $error("profile readback layout wrong");

	sync_release_a: assert property (synced_commit_s ##1 both_loaded_s ##0
		strobes_idle_s |=> !first_goal_load_q && !second_goal_load_q)
		else $error("synced commit pulse stretched");

	independent_load_a: assert property (ce && !profile_q.sync_update |=>
		first_goal_load_q == $past(first_goal_wr) &&
		second_goal_load_q == $past(second_goal_wr))
		else $error("independent goal commit wrong");

	index_read_a: assert property (rd_any && req.addr == ADDR_TABLE_INDEX |=>
		rdata_q == {27'h0, $past(index_q)})
		else $error("table index readback wrong");

	index_hold_a: assert property (!wr_index |=> $stable(index_q))
		else $error("table index changed without a write");

	rdata_hold_a: assert property (!rd_any |=> $stable(rdata_q))
		else $error("read data changed without a read");

	word_write_a: assert property (wr_word && index_mapped(index_q) |=>
		word_view == $past(req.wdata))
		else $error("mapped table word not written");

	first_axis_end_a: assert property (wr_word && index_q == 5'h09
		|=> table_q[AXIS_WORDS-1] == $past(req.wdata))
		else $error("first axis select word not written");

	second_axis_end_a: assert property (wr_word && index_q == 5'h19
		|=> table_q[TABLE_WORDS-1] == $past(req.wdata))
		else $error("second axis select word not written");

	unmapped_write_a: assert property (unmapped_write_s |=> $stable(table_fold))
		else $error("unmapped index write reached the table");

	unmapped_addr_a: assert property (rd_any && req.addr != ADDR_PROFILE &&
		req.addr != ADDR_TABLE_INDEX && req.addr != ADDR_TABLE_WORD
		|=> rdata_q == ZERO_WORD)
		else $error("unmapped address did not read zero");

endmodule // rmwt_regs
`default_nettype wire

//--- rmwt_regs_test.sv
`default_nettype none
module rmwt_regs_test import rmwt_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	logic          clk = 1'b0;
	logic          reset_n = 1'b0;
	logic          ce = 1'b1;
	rmwt_req_t     req;
	logic          f_wr;
	logic          s_wr;
	logic [31:0]   rdata_q;
	rmwt_profile_t profile_q;
	rmwt_behave_t  first_behave_q;
	rmwt_behave_t  second_behave_q;
	logic          f_load;
	logic          s_load;
	logic [31:0]   table_q [TABLE_WORDS];
	logic [4:0]    index_q;
	logic [4:0]    idx [6] = '{5'h00, 5'h09, 5'h10, 5'h19, 5'h0a, 5'h1f};
	logic [31:0]   v;
	int            errors = 0;
	int            comparisons = 0;

	always #10 clk = ~clk;

	rmwt_host host (.clk(clk), .req(req), .first_goal_wr(f_wr), .second_goal_wr(s_wr));

	rmwt_regs DUT (.clk(clk), .reset_n(reset_n), .ce(ce), .req(req), .rdata_q(rdata_q),
		.first_goal_wr(f_wr), .second_goal_wr(s_wr), .profile_q(profile_q),
		.first_behave_q(first_behave_q), .second_behave_q(second_behave_q),
		.first_goal_load_q(f_load), .second_goal_load_q(s_load),
		.table_q(table_q), .index_q(index_q));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic rd(input logic [6:0] a, input logic [31:0] exp);
		host.xfer(a, 1'b0, ZERO_WORD);
		check(rdata_q, exp);
	endtask

	task automatic close_out();
		if (errors == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Hang guard
	initial begin
		#200us;
		errors++;
		close_out();
	end

	initial begin
		repeat (16) @(posedge clk);
		@(negedge clk);
		reset_n = 1'b1;
		rd(ADDR_PROFILE, ZERO_WORD);
		check(32'(first_behave_q), 32'h0000_0008);
		rd(ADDR_TABLE_INDEX, ZERO_WORD);
		rd(ADDR_TABLE_WORD, TABLE_WORD_RST);
		rd(7'h0a, ZERO_WORD);
		for (int c = 0; c < 4; c++) begin
			host.xfer(ADDR_PROFILE, 1'b1, 32'((c << 2) | (3 - c)));
			rd(ADDR_PROFILE, 32'((c << 2) | (3 - c)));
			check(32'(second_behave_q), 32'(8 >> c));
			check(32'(first_behave_q), 32'(1 << c));
		end
		host.xfer(ADDR_PROFILE, 1'b1, 32'hffff_fff0);
		rd(ADDR_PROFILE, 32'h0000_0300);
		check(32'(profile_q), 32'h0000_0030);
		// Frozen clock enable must drop the write
		@(negedge clk);
		ce = 1'b0;
		host.xfer(ADDR_PROFILE, 1'b1, ZERO_WORD);
		ce = 1'b1;
		rd(ADDR_PROFILE, 32'h0000_0300);
		host.goal(1'b1, 1'b0);
		check(32'({f_load, s_load}), 32'h0000_0000);
		host.goal(1'b0, 1'b1);
		check(32'({f_load, s_load}), 32'h0000_0003);
		host.xfer(ADDR_PROFILE, 1'b1, ZERO_WORD);
		host.goal(1'b1, 1'b0);
		check(32'({f_load, s_load}), 32'h0000_0002);
		host.xfer(ADDR_PROFILE, 1'b1, 32'hffff_fef0);
		rd(ADDR_PROFILE, 32'h0000_0200);
		check(32'(profile_q), 32'h0000_0020);
		host.goal(1'b0, 1'b1);
		check(32'({f_load, s_load}), 32'h0000_0001);
		foreach (idx[i]) begin
			v = {27'h0, idx[i]} ^ 32'h5a5a_0000;
			host.xfer(ADDR_TABLE_INDEX, 1'b1, 32'hffff_ffe0 | 32'(idx[i]));
			rd(ADDR_TABLE_INDEX, 32'(idx[i]));
			host.xfer(ADDR_TABLE_WORD, 1'b1, v);
			if (idx[i][3:0] <= 4'h9) begin
				rd(ADDR_TABLE_WORD, v);
				check(table_q[idx[i][4] * 10 + idx[i][3:0]], v);
			end else begin
				rd(ADDR_TABLE_WORD, ZERO_WORD);
			end
		end
		check(table_q[1], TABLE_WORD_RST);
		check(table_q[10], 32'h5a5a_0010);
		// Mid-run reset must restore every field
		@(negedge clk);
		reset_n = 1'b0;
		repeat (2) @(negedge clk);
		reset_n = 1'b1;
		rd(ADDR_PROFILE, ZERO_WORD);
		rd(ADDR_TABLE_INDEX, ZERO_WORD);
		check(table_q[10], TABLE_WORD_RST);
		close_out();
	end
endmodule // rmwt_regs_test
`default_nettype wire
